// ==== rtl/csw_defines.vh ====
// Constants for the selective wake-up filter: map, fields, resets and timing
`ifndef CSW_DEFINES_VH
`define CSW_DEFINES_VH
// Register indices; byte address is four times the index
`define CSW_IDX_BIT_RATE 8'h26
`define CSW_IDX_ID0 8'h27
`define CSW_IDX_ID1 8'h28
`define CSW_IDX_ID2 8'h29
`define CSW_IDX_ID3 8'h2A
`define CSW_IDX_MASK0 8'h2B
`define CSW_IDX_MASK1 8'h2C
`define CSW_IDX_MASK2 8'h2D
`define CSW_IDX_MASK3 8'h2E
`define CSW_IDX_FRAME_CTRL 8'h2F
`define CSW_IDX_CONTROL 8'h30
`define CSW_IDX_STATUS 8'h31
// Writable bits per register
`define CSW_BIT_RATE_WMASK 8'h07
`define CSW_ID3_WMASK 8'h1F
`define CSW_FRAME_CTRL_WMASK 8'hCF
`define CSW_CONTROL_WMASK 8'h3F
// Field positions
`define CSW_FC_EXT_BIT 7
`define CSW_FC_DATA_EVAL_BIT 6
`define CSW_CTL_SEL_WAKE_BIT 0
`define CSW_CTL_BUS_WAKE_BIT 1
`define CSW_CTL_FD_TOL_BIT 4
`define CSW_CTL_CFG_VALID_BIT 5
`define CSW_ST_BUS_WAKE_BIT 0
`define CSW_ST_FDE_BIT 1
// Reset values
`define CSW_BIT_RATE_RST 8'h00
`define CSW_FRAME_CTRL_RST 8'h40
`define CSW_CONTROL_RST 8'h00
// Timing: bit lengths in 40 ns clocks per rate code
`define CSW_BITLEN_50K 10'h1F4
`define CSW_BITLEN_100K 10'h0FA
`define CSW_BITLEN_125K 10'h0C8
`define CSW_BITLEN_250K 10'h064
`define CSW_BITLEN_500K 10'h032
`define CSW_BITLEN_1000K 10'h019
// Wake pattern phase: the count ends at 25, so a phase lasts 26 clocks, just over 1000 ns
`define CSW_WUP_CYCLES 8'h19
`define CSW_ERR_LIMIT 6'h1F
`define CSW_IDLE_BITS 4'hB
`endif

// ==== rtl/csw_wake_filter.v ====
// Selective wake-up filter for a CAN transceiver with an APB register bank
// What this block does
// R1: Frame error before ACK increments counter
// R2: Error-free frame decrements counter
// R3: Ignore bus after CRC delimiter until SOF
// R4: Counter above 31 sets error flag, wakes
// R5: Counter clears on bias off, re-enable
// R6: Host writes valid bit to confirm settings
// R7: Any config write clears valid bit
// R8: Fallback mode wakes on standard pattern
// R9: Not offline or wake disabled: ignore
// R10: FD tolerant: FD control field decrements
// R11: FD frame never a valid wake frame
// R12: After FD control field wait bus idle
// R13: FD intolerant: FD frame increments counter
// R14: Rate code selects filter bit rate
// R15: Reserved rate codes act as 500k
// R16: Reference identifier in four byte registers
// R17: Mask bytes laid out like identifier
// R18: Frame control bit 7 picks format
// R19: Frame control bit 6 enables data eval
// R20: Length codes above eight mean eight
// R21: Mask bit one means don't care
// R22: Monitor only when enabled and valid
// R23: No data eval: ID match, good CRC
// R24: Data eval: ID, not remote, length, data
// R25: Bit timing follows selected rate code
// R26: Reserved bits read zero
`include "csw_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module csw_wake_filter (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire bus_rx,
  input wire bias_active,
  input wire [63:0] data_mask,
  output wire bus_wake_flag,
  output wire frame_detect_error_flag,
  output wire wake_request
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RX = 3'b010;
  localparam ST_SKIP = 3'b100;

  reg [7:0] bit_rate_ff;
  reg [31:0] ref_id_ff;
  reg [31:0] id_mask_ff;
  reg [7:0] frame_ctrl_ff;
  reg [7:0] control_ff;
  reg bus_wake_flag_ff;
  reg fde_flag_ff;
  reg [5:0] err_cnt_ff;
  reg [31:0] prdata_ff;
  reg rx_meta_ff;
  reg rx_sync_ff;
  reg rx_prev_ff;
  reg [9:0] phase_ff;
  reg [2:0] state_ff;
  reg [6:0] pos_ff;
  reg [3:0] same_ff;
  reg last_ff;
  reg [3:0] idle_ff;
  reg [14:0] crc_ff;
  reg [28:0] id_sh_ff;
  reg [63:0] data_sh_ff;
  reg ide_ff;
  reg rtr_ff;
  reg [3:0] dlc_ff;
  reg pn_active_q_ff;
  reg [1:0] wup_stage_ff;
  reg [7:0] wup_cnt_ff;

  wire [7:0] idx = paddr[9:2];
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
             (idx >= `CSW_IDX_BIT_RATE) && (idx <= `CSW_IDX_STATUS);
  wire cfg_wr = wr & hit & (idx <= `CSW_IDX_FRAME_CTRL);
  wire ctl_wr = wr & hit & (idx == `CSW_IDX_CONTROL);
  wire st_wr = wr & hit & (idx == `CSW_IDX_STATUS);

  // Mode and enables
  wire sel_wake_en = control_ff[`CSW_CTL_SEL_WAKE_BIT];
  wire bus_wake_en = control_ff[`CSW_CTL_BUS_WAKE_BIT];
  wire [1:0] trx_mode = control_ff[3:2];
  wire fd_tol_en = control_ff[`CSW_CTL_FD_TOL_BIT];
  wire cfg_valid = control_ff[`CSW_CTL_CFG_VALID_BIT];
  wire wake_ok = (trx_mode == 2'b00) & bus_wake_en; // [R9]
  wire pn_active = wake_ok & sel_wake_en & cfg_valid; // [R22] [R6]
  wire std_wake_mode = wake_ok & ~(sel_wake_en & cfg_valid); // [R8]

  // APB: always ready, unmapped or unaligned accesses get an error
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_ff;

  // Read mux; reserved bits are zero because reset and the write masks never put a one in them
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (idx)
      `CSW_IDX_BIT_RATE: rd_val[7:0] = bit_rate_ff;
      `CSW_IDX_ID0: rd_val[7:0] = ref_id_ff[7:0];
      `CSW_IDX_ID1: rd_val[7:0] = ref_id_ff[15:8];
      `CSW_IDX_ID2: rd_val[7:0] = ref_id_ff[23:16];
      `CSW_IDX_ID3: rd_val[7:0] = ref_id_ff[31:24];
      `CSW_IDX_MASK0: rd_val[7:0] = id_mask_ff[7:0];
      `CSW_IDX_MASK1: rd_val[7:0] = id_mask_ff[15:8];
      `CSW_IDX_MASK2: rd_val[7:0] = id_mask_ff[23:16];
      `CSW_IDX_MASK3: rd_val[7:0] = id_mask_ff[31:24];
      `CSW_IDX_FRAME_CTRL: rd_val[7:0] = frame_ctrl_ff;
      `CSW_IDX_CONTROL: rd_val[7:0] = control_ff;
      `CSW_IDX_STATUS: rd_val = {18'h0, err_cnt_ff, 6'h0, fde_flag_ff, bus_wake_flag_ff}; // [R26]
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup phase so it is stable in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_ff <= hit ? rd_val : 32'h0000_0000;
    end
  end

  // Configuration registers with write masks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_rate_ff <= `CSW_BIT_RATE_RST;
      ref_id_ff <= 32'h0000_0000;
      id_mask_ff <= 32'h0000_0000;
      frame_ctrl_ff <= `CSW_FRAME_CTRL_RST;
    end else if (cfg_wr) begin
      case (idx)
        `CSW_IDX_BIT_RATE: bit_rate_ff <= pwdata[7:0] & `CSW_BIT_RATE_WMASK; // [R26]
        `CSW_IDX_ID0: ref_id_ff[7:0] <= pwdata[7:0]; // [R16]
        `CSW_IDX_ID1: ref_id_ff[15:8] <= pwdata[7:0];
        `CSW_IDX_ID2: ref_id_ff[23:16] <= pwdata[7:0];
        `CSW_IDX_ID3: ref_id_ff[31:24] <= pwdata[7:0] & `CSW_ID3_WMASK;
        `CSW_IDX_MASK0: id_mask_ff[7:0] <= pwdata[7:0]; // [R17]
        `CSW_IDX_MASK1: id_mask_ff[15:8] <= pwdata[7:0];
        `CSW_IDX_MASK2: id_mask_ff[23:16] <= pwdata[7:0];
        `CSW_IDX_MASK3: id_mask_ff[31:24] <= pwdata[7:0] & `CSW_ID3_WMASK;
        `CSW_IDX_FRAME_CTRL: frame_ctrl_ff <= pwdata[7:0] & `CSW_FRAME_CTRL_WMASK;
        default: bit_rate_ff <= bit_rate_ff;
      endcase
    end
  end

  // Control register; a config write drops the valid bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_ff <= `CSW_CONTROL_RST;
    end else if (ctl_wr) begin
      control_ff <= pwdata[7:0] & `CSW_CONTROL_WMASK; // [R6]
    end else if (cfg_wr) begin
      control_ff[`CSW_CTL_CFG_VALID_BIT] <= 1'b0; // [R7]
    end
  end

  // Nominal bit length in clocks from the rate code
  reg [9:0] bit_len;
  always @* begin
    case (bit_rate_ff[2:0]) // [R14] [R25]
      3'b000: bit_len = `CSW_BITLEN_50K;
      3'b001: bit_len = `CSW_BITLEN_100K;
      3'b010: bit_len = `CSW_BITLEN_125K;
      3'b011: bit_len = `CSW_BITLEN_250K;
      3'b111: bit_len = `CSW_BITLEN_1000K;
      default: bit_len = `CSW_BITLEN_500K; // [R15]
    endcase
  end

  // Receive pin synchroniser; the second stage gives the bit, the third stage the falling edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= bus_rx;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  // Each recessive-to-dominant edge restarts the bit; simple but robust
  // against slow drift since every stuffed frame has frequent edges
  wire fall = rx_prev_ff & ~rx_sync_ff;
  wire [9:0] nxt_phase = (fall || phase_ff == bit_len - 10'd1) ? 10'd0 : phase_ff + 10'd1;
  wire sample = (phase_ff == {1'b0, bit_len[9:1]});
  wire b = rx_sync_ff;

  // Frame layout derived from what has been received so far
  wire [3:0] dlc_n = dlc_ff[3] ? 4'd8 : dlc_ff;
  wire [3:0] cfg_dlc = frame_ctrl_ff[3] ? 4'd8 : frame_ctrl_ff[3:0]; // [R20]
  wire [6:0] ctrl_end = ide_ff ? 7'd38 : 7'd18;
  wire [6:0] nbits = rtr_ff ? 7'd0 : {dlc_n, 3'b000};
  wire [6:0] crc_start = ctrl_end + 7'd1 + nbits;
  wire [6:0] delim_pos = crc_start + 7'd15;
  wire fdf_pos = ide_ff ? (pos_ff == 7'd33) : (pos_ff == 7'd14);
  wire [14:0] crc_step = {crc_ff[13:0], 1'b0} ^ ((b ^ crc_ff[14]) ? 15'h4599 : 15'h0000);

  // Acceptance test
  wire [28:0] ref_id = frame_ctrl_ff[`CSW_FC_EXT_BIT] ? {ref_id_ff[28:24], ref_id_ff[23:0]} :
                       {18'h0, ref_id_ff[28:24], ref_id_ff[23:18]}; // [R16] [R18]
  wire [28:0] id_msk = frame_ctrl_ff[`CSW_FC_EXT_BIT] ? {id_mask_ff[28:24], id_mask_ff[23:0]} :
                       {18'h0, id_mask_ff[28:24], id_mask_ff[23:18]}; // [R17]
  wire [28:0] rx_id = ide_ff ? id_sh_ff : {18'h0, id_sh_ff[10:0]};
  wire fmt_ok = (ide_ff == frame_ctrl_ff[`CSW_FC_EXT_BIT]);
  wire id_ok = fmt_ok && (((rx_id ^ ref_id) & ~id_msk) == 29'h0); // [R21]
  wire data_ok = ~rtr_ff && (dlc_n == cfg_dlc) &&
                 ((cfg_dlc == 4'd0) || |(data_sh_ff & data_mask)); // [R24]
  wire accept = id_ok && (~frame_ctrl_ff[`CSW_FC_DATA_EVAL_BIT] || data_ok); // [R19] [R23]

  // Parser events, one cycle each
  reg inc_ev;
  reg dec_ev;
  reg wuf_ev;
  reg [2:0] nxt_state;
  reg [6:0] nxt_pos;
  always @* begin
    inc_ev = 1'b0;
    dec_ev = 1'b0;
    wuf_ev = 1'b0;
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!pn_active) nxt_state = ST_SKIP;
        else if (sample && !b) begin
          nxt_state = ST_RX;
          nxt_pos = 7'd1;
        end
      end
      ST_RX: begin
        if (!pn_active) nxt_state = ST_SKIP;
        else if (sample) begin
          // Stuffing also covers the bit after the last CRC bit
          if (pos_ff <= delim_pos && same_ff == 4'd5) begin
            if (b == last_ff) begin
              inc_ev = 1'b1; // [R1]
              nxt_state = ST_SKIP;
            end
          end else if (fdf_pos && b) begin
            inc_ev = ~fd_tol_en; // [R13]
            dec_ev = fd_tol_en; // [R10] [R11]
            nxt_state = ST_SKIP; // [R12]
          end else if (pos_ff == delim_pos) begin
            if (b && crc_ff == 15'h0000) begin
              dec_ev = 1'b1; // [R2]
              wuf_ev = accept; // [R23] [R24]
            end else begin
              inc_ev = 1'b1; // [R1]
            end
            nxt_state = ST_SKIP; // [R3]
          end else begin
            nxt_pos = pos_ff + 7'd1;
          end
        end
      end
      ST_SKIP: begin
        if (pn_active && idle_ff == `CSW_IDLE_BITS) nxt_state = ST_IDLE; // [R3] [R12]
      end
      default: nxt_state = ST_SKIP;
    endcase
  end

  // Bit timing, destuffing and field capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 10'd0;
      state_ff <= ST_SKIP;
      pos_ff <= 7'd0;
      same_ff <= 4'd0;
      last_ff <= 1'b1;
      idle_ff <= 4'd0;
      crc_ff <= 15'h0000;
      id_sh_ff <= 29'h0;
      data_sh_ff <= 64'h0;
      ide_ff <= 1'b0;
      rtr_ff <= 1'b0;
      dlc_ff <= 4'd0;
    end else begin
      phase_ff <= nxt_phase;
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
      if (sample) begin
        // Only recessive bits outside a frame count, so a skip entered from a frame waits a full idle gap
        idle_ff <= (!b || state_ff == ST_RX) ? 4'd0 :
                   (idle_ff == `CSW_IDLE_BITS) ? idle_ff : idle_ff + 4'd1; // [R12]
      end
      if (state_ff == ST_IDLE && nxt_state == ST_RX) begin
        // Start of frame: the SOF bit is already part of the stuff run
        same_ff <= 4'd1;
        last_ff <= 1'b0;
        crc_ff <= 15'h0000;
        id_sh_ff <= 29'h0;
        data_sh_ff <= 64'h0;
        ide_ff <= 1'b0;
        rtr_ff <= 1'b0;
        dlc_ff <= 4'd0;
      end else if (state_ff == ST_RX && sample) begin
        last_ff <= b;
        same_ff <= (same_ff == 4'd5 || b != last_ff) ? 4'd1 : same_ff + 4'd1; // [R25]
        if (nxt_pos != pos_ff) begin
          crc_ff <= crc_step;
          if (pos_ff <= 7'd11 || (ide_ff && pos_ff >= 7'd14 && pos_ff <= 7'd31)) begin
            id_sh_ff <= {id_sh_ff[27:0], b};
          end
          if (pos_ff == 7'd12 || (ide_ff && pos_ff == 7'd32)) rtr_ff <= b;
          if (pos_ff == 7'd13) ide_ff <= b;
          if (pos_ff > ctrl_end - 7'd4 && pos_ff <= ctrl_end) dlc_ff <= {dlc_ff[2:0], b};
          if (pos_ff > ctrl_end && pos_ff < crc_start) data_sh_ff <= {data_sh_ff[62:0], b};
        end
      end
    end
  end

  // Standard wake-up pattern: dominant, recessive, dominant phases
  wire wup_lvl = wup_stage_ff[0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wup_stage_ff <= 2'd0;
      wup_cnt_ff <= 8'd0;
    end else if (!std_wake_mode || wup_stage_ff == 2'd3) begin
      wup_stage_ff <= 2'd0; // [R9]
      wup_cnt_ff <= 8'd0;
    end else if (b != wup_lvl) begin
      wup_cnt_ff <= 8'd0;
    end else if (wup_cnt_ff == `CSW_WUP_CYCLES) begin
      wup_stage_ff <= wup_stage_ff + 2'd1;
      wup_cnt_ff <= 8'd0;
    end else begin
      wup_cnt_ff <= wup_cnt_ff + 8'd1;
    end
  end
  wire wup_ev = std_wake_mode && wup_stage_ff == 2'd3; // [R8]

  // Error counter and sticky flags; a set wins over a write-one clear
  wire cnt_clr = ~bias_active & pn_active & ~pn_active_q_ff; // [R5]
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_ff <= 6'd0;
      fde_flag_ff <= 1'b0;
      bus_wake_flag_ff <= 1'b0;
      pn_active_q_ff <= 1'b0;
    end else begin
      pn_active_q_ff <= pn_active;
      if (cnt_clr) err_cnt_ff <= 6'd0;
      else if (inc_ev && err_cnt_ff <= `CSW_ERR_LIMIT) err_cnt_ff <= err_cnt_ff + 6'd1;
      else if (dec_ev && err_cnt_ff != 6'd0) err_cnt_ff <= err_cnt_ff - 6'd1;
      if (inc_ev && err_cnt_ff == `CSW_ERR_LIMIT) fde_flag_ff <= 1'b1; // [R4] [R13]
      else if (st_wr && pwdata[`CSW_ST_FDE_BIT]) fde_flag_ff <= 1'b0;
      if (wuf_ev || wup_ev) bus_wake_flag_ff <= 1'b1;
      else if (st_wr && pwdata[`CSW_ST_BUS_WAKE_BIT]) bus_wake_flag_ff <= 1'b0;
    end
  end

  assign bus_wake_flag = bus_wake_flag_ff;
  assign frame_detect_error_flag = fde_flag_ff;
  assign wake_request = bus_wake_flag_ff | fde_flag_ff; // [R4]
endmodule // csw_wake_filter
`default_nettype wire

// ==== testbench/csw_wake_filter_assertions.sv ====
// Port-level checker for the selective wake-up filter
`timescale 1ns/10ps
`default_nettype none
module csw_wake_filter_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire bus_wake_flag,
  input wire frame_detect_error_flag,
  input wire wake_request
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Decoded access phase
  wire acc = psel && penable;
  wire [7:0] idx = paddr[9:2];
  wire bad = idx < 8'h26 || idx > 8'h31 || paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0;
  wire rd_ok = acc && !pwrite && !bad;
  wire clr_bw = acc && pwrite && !bad && idx == 8'h31 && pwdata[0];
  wire clr_fde = acc && pwrite && !bad && idx == 8'h31 && pwdata[1];
  sequence cfg_write;
    acc && pwrite && !bad && idx <= 8'h2F;
  endsequence
  sequence ctl_read;
    psel && !penable && !pwrite && idx == 8'h30 ##1 acc;
  endsequence
  wake_or_a: assert property (wake_request == (bus_wake_flag | frame_detect_error_flag))
    else $error("wake request not the OR of the flags");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  unmapped_err_a: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  cfg_clears_a: assert property (cfg_write ##2 ctl_read |-> !prdata[5])
    else $error("config valid kept after config write");
  rate_rsvd_a: assert property (rd_ok && idx == 8'h26 |-> prdata[31:3] == 29'h0)
    else $error("rate register reserved bits set");
  id_high_a: assert property (rd_ok && (idx == 8'h2A || idx == 8'h2E) |-> prdata[31:5] == 27'h0)
    else $error("identifier top byte reserved bits set");
  cnt_bound_a: assert property (rd_ok && idx == 8'h31 |-> prdata[13:8] <= 6'h20)
    else $error("error counter beyond limit");
  bw_w1c_a: assert property ($fell(bus_wake_flag) |-> $past(clr_bw))
    else $error("bus wake flag lost without clear");
  fde_w1c_a: assert property ($fell(frame_detect_error_flag) |-> $past(clr_fde))
    else $error("error flag lost without clear");
endmodule // csw_wake_filter_assertions
bind csw_wake_filter csw_wake_filter_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_wake_flag(bus_wake_flag),
  .frame_detect_error_flag(frame_detect_error_flag), .wake_request(wake_request));
`default_nettype wire

// ==== testbench/csw_can_node.sv ====
// Behavioural CAN node driving the filter's receive line
`timescale 1ns/10ps
`default_nettype none
module csw_can_node (
  input wire logic pclk,
  output logic bus_rx
);
  int bit_clks = 25; // Clocks per bit; 25 matches the 1000 kbit/s code
  logic ext = 1'b0; // Extended frames take ext_id as the low 18 ID bits
  logic [17:0] ext_id = 18'h00000;
  initial bus_rx = 1'b1;
  // Frame with CRC and stuffing; err breaks stuffing, fdf sets the FD bit and the tail follows
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] dat,
                      input logic fdf, input logic err);
    logic q[$];
    logic s[$];
    logic [14:0] crc;
    int run;
    crc = 15'h0000;
    run = 0;
    q.push_back(1'b0);
    for (int i = 10; i >= 0; i--) q.push_back(id[i]);
    // Extended: SRR and EXTENDED_FORMAT_SELECT recessive, 18 more ID bits, RTR, FDF, r0
    if (ext) begin
      q.push_back(1'b1);
      q.push_back(1'b1);
      for (int i = 17; i >= 0; i--) q.push_back(ext_id[i]);
      q.push_back(1'b0);
      q.push_back(fdf);
      q.push_back(1'b0);
    end else begin
      q.push_back(1'b0);
      q.push_back(1'b0);
      q.push_back(fdf);
    end
    for (int i = 3; i >= 0; i--) q.push_back(dlc[i]);
    for (int i = 0; i < 8 * (dlc > 8 ? 8 : dlc); i++) q.push_back(dat[7 - i % 8]);
    foreach (q[i]) crc = {crc[13:0], 1'b0} ^ ((q[i] ^ crc[14]) ? 15'h4599 : 15'h0000);
    for (int i = 14; i >= 0; i--) q.push_back(crc[i]);
    foreach (q[i]) begin
      if (run == 5) begin
        s.push_back(!s[$]);
        run = 1;
      end
      run = (s.size() > 0 && s[$] == q[i]) ? run + 1 : 1;
      s.push_back(q[i]);
    end
    if (run == 5) s.push_back(!s[$]);
    // Six dominant bits after the first three bits are a stuffing violation
    if (err) begin
      s = s[0:2];
      repeat (6) s.push_back(1'b0);
    end
    repeat (10) s.push_back(1'b1);
    // Idle first so the filter has seen bus idle before SOF
    repeat (13 * bit_clks) @(posedge pclk);
    foreach (s[i]) begin
      bus_rx <= s[i];
      repeat (bit_clks) @(posedge pclk);
    end
    bus_rx <= 1'b1;
  endtask
  // Plain wake-up pattern: dominant, recessive, dominant, each past the phase time
  task automatic pattern;
    repeat (3) begin
      bus_rx <= !bus_rx;
      repeat (40) @(posedge pclk);
    end
    bus_rx <= 1'b1;
    repeat (40) @(posedge pclk);
  endtask
endmodule // csw_can_node
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the selective wake-up filter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic bias_active = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [63:0] data_mask = 64'h0;
  logic [31:0] prdata;
  logic pready, pslverr, bus_rx, bus_wake_flag, frame_detect_error_flag, wake_request;
  int n_fail = 0;
  int check_count = 0;
  always #20 pclk = ~pclk;
  csw_wake_filter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_rx(bus_rx), .bias_active(bias_active), .data_mask(data_mask),
    .bus_wake_flag(bus_wake_flag), .frame_detect_error_flag(frame_detect_error_flag),
    .wake_request(wake_request));
  csw_can_node u_node (.pclk(pclk), .bus_rx(bus_rx));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the wait on pready is bounded
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, v, d, e);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
    chk(d, exp);
  endtask
  // Status holds counter, error flag and wake flag; wake request follows the flags
  task automatic st(input logic [5:0] c, input logic f, input logic b);
    rdc(8'h31, {18'h0, c, 6'h00, f, b});
    chk({31'h0, wake_request}, {31'h0, f | b});
  endtask
  task automatic cfg(input logic [7:0] fc, input logic [7:0] ctl);
    wr(8'h26, 8'h07);
    wr(8'h29, 8'h80);
    wr(8'h2A, 8'h06);
    wr(8'h2D, 8'h1C);
    wr(8'h2E, 8'h00);
    wr(8'h2F, fc);
    wr(8'h30, ctl);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    rdc(8'h26, 32'h00);
    rdc(8'h2F, 32'h40);
    wr(8'h26, 8'hFF);
    rdc(8'h26, 32'h07);
    wr(8'h2E, 8'hFF);
    rdc(8'h2E, 32'h1F);
    wr(8'h2F, 8'hFF);
    rdc(8'h2F, 32'hCF);
    wr(8'h30, 8'h20);
    wr(8'h27, 8'h55);
    rdc(8'h30, 32'h00);
    apb(1'b0, 8'h10, 8'h00, d, e);
    chk({e, d[30:0]}, 32'h80000000);
  endtask
  task automatic t_match;
    cfg(8'h00, 8'h23);
    u_node.send(11'h1A5, 4'h0, 8'h00, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b1);
    wr(8'h31, 8'h01);
    u_node.send(11'h1B0, 4'h0, 8'h00, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b0);
  endtask
  task automatic t_err;
    u_node.send(11'h1B0, 4'h0, 8'h00, 1'b0, 1'b1);
    st(6'h01, 1'b0, 1'b0);
    u_node.send(11'h1B0, 4'h0, 8'h00, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b0);
  endtask
  task automatic t_fd;
    wr(8'h30, 8'h33);
    u_node.send(11'h1B0, 4'h0, 8'h00, 1'b0, 1'b1);
    u_node.send(11'h1A0, 4'h0, 8'h00, 1'b1, 1'b0);
    st(6'h00, 1'b0, 1'b0);
    wr(8'h30, 8'h23);
    u_node.send(11'h1A0, 4'h0, 8'h00, 1'b1, 1'b0);
    st(6'h01, 1'b0, 1'b0);
  endtask
  task automatic t_over;
    repeat (30) u_node.send(11'h1B0, 4'h0, 8'h00, 1'b0, 1'b1);
    st(6'h1F, 1'b0, 1'b0);
    u_node.send(11'h1B0, 4'h0, 8'h00, 1'b0, 1'b1);
    st(6'h20, 1'b1, 1'b0);
    bias_active <= 1'b1;
    wr(8'h30, 8'h00);
    wr(8'h30, 8'h23);
    st(6'h20, 1'b1, 1'b0);
    bias_active <= 1'b0;
    wr(8'h30, 8'h00);
    wr(8'h30, 8'h23);
    st(6'h00, 1'b1, 1'b0);
    wr(8'h31, 8'h02);
  endtask
  task automatic t_data;
    data_mask <= 64'h00000000000000A8;
    cfg(8'h41, 8'h23);
    u_node.send(11'h1A0, 4'h2, 8'h30, 1'b0, 1'b0);
    u_node.send(11'h1A0, 4'h1, 8'h54, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b0);
    u_node.send(11'h1A0, 4'h1, 8'h30, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b1);
    wr(8'h31, 8'h01);
    cfg(8'h4F, 8'h23);
    u_node.send(11'h1A0, 4'h8, 8'h30, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b1);
    wr(8'h31, 8'h01);
    // Reserved rate code runs at 500 kbit/s
    wr(8'h26, 8'h04);
    wr(8'h30, 8'h23);
    u_node.bit_clks = 50;
    u_node.send(11'h1A0, 4'h8, 8'h30, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b1);
    wr(8'h31, 8'h01);
    u_node.bit_clks = 25;
    // Extended format with masked low base bits, then a standard frame refused
    cfg(8'h80, 8'h23);
    u_node.ext = 1'b1;
    u_node.ext_id = 18'h00055;
    u_node.send(11'h1A3, 4'h0, 8'h00, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b1);
    wr(8'h31, 8'h01);
    u_node.ext = 1'b0;
    u_node.send(11'h1A3, 4'h0, 8'h00, 1'b0, 1'b0);
    st(6'h00, 1'b0, 1'b0);
  endtask
  // Pattern wake only in fallback, never outside offline or with bus wake off
  task automatic t_fallback;
    wr(8'h30, 8'h03);
    u_node.pattern();
    st(6'h00, 1'b0, 1'b1);
    wr(8'h31, 8'h01);
    wr(8'h30, 8'h07);
    u_node.pattern();
    wr(8'h30, 8'h01);
    u_node.pattern();
    st(6'h00, 1'b0, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_match();
    t_err();
    t_fd();
    t_over();
    t_data();
    t_fallback();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
